// ### rtl/gpl_defines.svh
`ifndef GPL_DEFINES_SVH
`define GPL_DEFINES_SVH

// ----------------------------------------------------------------------
// register offsets on the configuration port
// ----------------------------------------------------------------------
`define GPL_OFF_PIN_A   8'h3C
`define GPL_OFF_PIN_B   8'h3D
`define GPL_OFF_PIN_C   8'h3E
`define GPL_OFF_STATUS  8'h48
`define GPL_OFF_MASK    8'h49
`define GPL_OFF_DISABLE 8'h4A
`define GPL_OFF_DATA    8'h4B

// ----------------------------------------------------------------------
// field positions inside a pin configuration register
// ----------------------------------------------------------------------
`define GPL_BIT_DIR     0
`define GPL_BIT_POL     1
`define GPL_BIT_ALT     2
`define GPL_BIT_ALT_HI  3
`define GPL_BIT_OD      7

// writable bits; reserved bits are kept at zero
`define GPL_WMASK_AC    8'h8F
`define GPL_WMASK_B     8'h87

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define GPL_CFG_RESET   8'h01
`define GPL_DIS_RESET   8'h00
`define GPL_STAT_RESET  3'h0
`define GPL_DATA_RESET  3'h0

// status bit positions
`define GPL_ST_IRQ2     0
`define GPL_ST_IRQ3     1
`define GPL_ST_REFUSED  2

`endif

// ### rtl/gpl_pkg.sv
package gpl_pkg;
  // ----------------------------------------------------------------------
  // alternate function codes of the two-bit fields
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    GPL_A_GPIO,
    GPL_A_DENSITY,
    GPL_A_IRQ,
    GPL_A_RSVD
  } gpl_func_a_e;

  typedef enum logic [1:0] {
    GPL_C_GPIO,
    GPL_C_LOCK,
    GPL_C_RSVD,
    GPL_C_IRQ
  } gpl_func_c_e;

  typedef logic [7:0] gpl_byte_t;
endpackage

// ### rtl/gpl_pin.sv
// one pad: input synchroniser, edge detect and registered output drive
module gpl_pin (
  input  wire logic ref_clk_in,
  input  wire logic rst_b_in,
  input  wire logic dir_in,
  input  wire logic pol_in,
  input  wire logic od_in,
  input  wire logic alt_drive_in,
  input  wire logic alt_val_in,
  input  wire logic gpio_val_in,
  input  wire logic pad_in,
  output logic      pad_out,
  output logic      pad_oe_b_out,
  output logic      level_out,
  output logic      edge_out
);
  logic sync_a;
  logic sync_b;
  logic prev;
  logic next_pad;
  logic next_oe_b;
  logic val;

  // ----------------------------------------------------------------------
  // drive computation
  // ----------------------------------------------------------------------
  // open drain never drives high, so a one releases the pad
  always_comb begin
    val       = (alt_drive_in ? alt_val_in : gpio_val_in) ^ pol_in;
    next_pad  = od_in ? 1'h0 : val;
    next_oe_b = dir_in | (od_in & val);
  end

  // pad input passes two flops before anything reads it
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      sync_a       <= 1'h0;
      sync_b       <= 1'h0;
      prev         <= 1'h0;
      pad_out      <= 1'h0;
      pad_oe_b_out <= 1'h1;
    end else begin
      sync_a       <= pad_in;
      sync_b       <= sync_a;
      prev         <= sync_b;
      pad_out      <= next_pad;
      pad_oe_b_out <= next_oe_b;
    end
  end

  assign level_out = sync_b;
  assign edge_out  = sync_b ^ prev; // either edge

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);

  a_od_never_high: assert property (od_in |=> pad_out == 1'h0)
    else $error("open drain pad drove a one");
endmodule

// ### rtl/gpl_top.sv
`include "gpl_defines.svh"

module gpl_top (
  input  wire logic            ref_clk_in,
  input  wire logic            rst_b_in,
  input  wire logic            main_rst_b_in,
  input  wire logic            bus_rst_b_in,
  input  wire logic [7:0]      addr_in,
  input  wire gpl_pkg::gpl_byte_t wdata_in,
  input  wire logic            wr_in,
  input  wire logic            rd_in,
  output gpl_pkg::gpl_byte_t   rdata_out,
  input  wire logic [2:0]      pad_in,
  output logic [2:0]           pad_out,
  output logic [2:0]           pad_oe_b_out,
  input  wire logic            drive_density_in,
  input  wire logic            wake_event_in,
  output logic                 irq_out,
  output gpl_pkg::gpl_byte_t   disable_reg_out,
  output logic                 disable_reg_lock_ctrl_out
);
  import gpl_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  gpl_byte_t   pin_a_config;
  gpl_byte_t   pin_b_config;
  gpl_byte_t   pin_c_config;
  logic [2:0]  status;
  logic [2:0]  mask;
  logic [2:0]  gpio_data;
  gpl_byte_t   next_pin_a_config;
  gpl_byte_t   next_pin_b_config;
  gpl_byte_t   next_pin_c_config;
  logic [2:0]  next_status;
  logic [2:0]  next_mask;
  logic [2:0]  next_gpio_data;
  gpl_byte_t   next_disable;
  gpl_byte_t   next_rdata;
  logic        next_irq;
  logic        next_lock;

  gpl_func_a_e func_a;
  gpl_func_c_e func_c;
  logic        lock_mode;
  logic        dis_locked;
  logic [2:0]  events;
  logic [2:0]  dir;
  logic [2:0]  pol;
  logic [2:0]  od;
  logic [2:0]  alt_drive;
  logic [2:0]  alt_val;
  logic [2:0]  level;
  logic [2:0]  edge_seen;
  logic [2:0]  in_value;

  // address match, used by every write and by the read mux
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // ----------------------------------------------------------------------
  // function decode
  // ----------------------------------------------------------------------
  always_comb begin
    func_a     = gpl_func_a_e'(
                   pin_a_config[`GPL_BIT_ALT_HI:`GPL_BIT_ALT]);
    func_c     = gpl_func_c_e'(
                   pin_c_config[`GPL_BIT_ALT_HI:`GPL_BIT_ALT]);
    lock_mode  = (func_c == GPL_C_LOCK);
    dis_locked = lock_mode & level[2];
  end

  // per-pin drive controls; interrupt and lock inputs never drive
  always_comb begin
    dir[0] = pin_a_config[`GPL_BIT_DIR] | (func_a == GPL_A_IRQ);
    pol[0] = pin_a_config[`GPL_BIT_POL];
    od[0]  = pin_a_config[`GPL_BIT_OD];
    alt_drive[0] = (func_a == GPL_A_DENSITY);
    alt_val[0]   = drive_density_in;
    dir[1] = pin_b_config[`GPL_BIT_DIR];
    pol[1] = pin_b_config[`GPL_BIT_POL];
    od[1]  = pin_b_config[`GPL_BIT_OD];
    alt_drive[1] = pin_b_config[`GPL_BIT_ALT];
    alt_val[1]   = ~wake_event_in;
    dir[2] = pin_c_config[`GPL_BIT_DIR] | lock_mode
             | (func_c == GPL_C_IRQ);
    pol[2] = pin_c_config[`GPL_BIT_POL] & ~lock_mode;
    od[2]  = pin_c_config[`GPL_BIT_OD];
    alt_drive[2] = 1'h0;
    alt_val[2]   = 1'h0;
    in_value     = level ^ pol;
  end

  // ----------------------------------------------------------------------
  // pads
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < 3; i++) begin : g_pin
    gpl_pin u_pin (
      .ref_clk_in   (ref_clk_in),
      .rst_b_in     (rst_b_in),
      .dir_in       (dir[i]),
      .pol_in       (pol[i]),
      .od_in        (od[i]),
      .alt_drive_in (alt_drive[i]),
      .alt_val_in   (alt_val[i]),
      .gpio_val_in  (gpio_data[i]),
      .pad_in       (pad_in[i]),
      .pad_out      (pad_out[i]),
      .pad_oe_b_out (pad_oe_b_out[i]),
      .level_out    (level[i]),
      .edge_out     (edge_seen[i])
    );
  end

  // ----------------------------------------------------------------------
  // register writes and events
  // ----------------------------------------------------------------------
  // a set in the same cycle as a write-one clear keeps the bit set
  always_comb begin
    events = 3'h0;
    events[`GPL_ST_IRQ2]    = edge_seen[0] & (func_a == GPL_A_IRQ);
    events[`GPL_ST_IRQ3]    = edge_seen[2] & (func_c == GPL_C_IRQ);
    events[`GPL_ST_REFUSED] = wr_in & hit(addr_in, `GPL_OFF_DISABLE)
                              & dis_locked;
    next_pin_a_config = pin_a_config;
    next_pin_b_config = pin_b_config;
    next_pin_c_config = pin_c_config;
    next_mask         = mask;
    next_gpio_data    = gpio_data;
    next_disable      = disable_reg_out;
    next_status       = status;
    if (wr_in) begin
      if (hit(addr_in, `GPL_OFF_PIN_A)) begin
        next_pin_a_config = wdata_in & `GPL_WMASK_AC;
      end else if (hit(addr_in, `GPL_OFF_PIN_B)) begin
        next_pin_b_config = wdata_in & `GPL_WMASK_B;
      end else if (hit(addr_in, `GPL_OFF_PIN_C)) begin
        next_pin_c_config = wdata_in & `GPL_WMASK_AC;
        if (lock_mode) begin
          // field stays put once locking is chosen
          next_pin_c_config[`GPL_BIT_ALT_HI:`GPL_BIT_ALT] = 2'h1;
        end
      end else if (hit(addr_in, `GPL_OFF_STATUS)) begin
        next_status = status & ~wdata_in[2:0];
      end else if (hit(addr_in, `GPL_OFF_MASK)) begin
        next_mask = wdata_in[2:0];
      end else if (hit(addr_in, `GPL_OFF_DISABLE)) begin
        if (!dis_locked) begin
          next_disable = wdata_in;
        end
      end else if (hit(addr_in, `GPL_OFF_DATA)) begin
        next_gpio_data = wdata_in[2:0];
      end
    end
    next_status = next_status | events;
    // main power or bus reset leaves only the lock field cleared
    if (!main_rst_b_in || !bus_rst_b_in) begin
      next_pin_c_config[`GPL_BIT_ALT_HI:`GPL_BIT_ALT] = 2'h0;
    end
    next_irq  = |(next_status & next_mask);
    next_lock = (next_pin_c_config[`GPL_BIT_ALT_HI:`GPL_BIT_ALT] == 2'h1);
  end

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  // unmapped addresses answer zero
  always_comb begin
    next_rdata = 8'h00;
    if (!rd_in) begin
      next_rdata = 8'h00;
    end else if (hit(addr_in, `GPL_OFF_PIN_A)) begin
      next_rdata = pin_a_config;
    end else if (hit(addr_in, `GPL_OFF_PIN_B)) begin
      next_rdata = pin_b_config;
    end else if (hit(addr_in, `GPL_OFF_PIN_C)) begin
      next_rdata = pin_c_config;
    end else if (hit(addr_in, `GPL_OFF_STATUS)) begin
      next_rdata = {5'h00, status};
    end else if (hit(addr_in, `GPL_OFF_MASK)) begin
      next_rdata = {5'h00, mask};
    end else if (hit(addr_in, `GPL_OFF_DISABLE)) begin
      next_rdata = disable_reg_out;
    end else if (hit(addr_in, `GPL_OFF_DATA)) begin
      next_rdata = {1'h0, gpio_data, 1'h0, in_value};
    end
  end

  // standby reset brings every register to its default
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      pin_a_config              <= `GPL_CFG_RESET;
      pin_b_config              <= `GPL_CFG_RESET;
      pin_c_config              <= `GPL_CFG_RESET;
      status                    <= `GPL_STAT_RESET;
      mask                      <= `GPL_STAT_RESET;
      gpio_data                 <= `GPL_DATA_RESET;
      disable_reg_out           <= `GPL_DIS_RESET;
      rdata_out                 <= 8'h00;
      irq_out                   <= 1'h0;
      disable_reg_lock_ctrl_out <= 1'h0;
    end else begin
      pin_a_config              <= next_pin_a_config;
      pin_b_config              <= next_pin_b_config;
      pin_c_config              <= next_pin_c_config;
      status                    <= next_status;
      mask                      <= next_mask;
      gpio_data                 <= next_gpio_data;
      disable_reg_out           <= next_disable;
      rdata_out                 <= next_rdata;
      irq_out                   <= next_irq;
      disable_reg_lock_ctrl_out <= next_lock;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);

  a_rsvd_read_zero: assert property (
    rd_in && hit(addr_in, `GPL_OFF_PIN_A) |=> rdata_out[6:4] == 3'h0)
    else $error("reserved bits of pin A read nonzero");

  a_dir_input_hold: assert property (
    pin_b_config[`GPL_BIT_DIR] |=> pad_oe_b_out[1])
    else $error("pin B drove while set as input");

  a_pol_invert_out: assert property (
    pin_b_config[2:0] == 3'h2 && !pin_b_config[`GPL_BIT_OD]
    |=> pad_out[1] == !$past(gpio_data[1]) && !pad_oe_b_out[1])
    else $error("inverted gpio output wrong");

  a_wake_active_low: assert property (
    pin_b_config[2:0] == 3'h4 && !pin_b_config[`GPL_BIT_OD]
    |=> pad_out[1] == !$past(wake_event_in))
    else $error("wake output not active low");

  a_density_routed: assert property (
    pin_a_config == 8'h04 |=> pad_out[0] == $past(drive_density_in))
    else $error("density output not routed");

  a_lock_is_input: assert property (
    lock_mode |=> pad_oe_b_out[2])
    else $error("pin C drove in lock mode");

  a_lock_field_held: assert property (
    lock_mode && main_rst_b_in && bus_rst_b_in
    |=> pin_c_config[3:2] == 2'h1 [*1])
    else $error("lock field changed without reset");

  a_field_reset_clear: assert property (
    !main_rst_b_in || !bus_rst_b_in |=> pin_c_config[3:2] == 2'h0)
    else $error("lock field survived reset");

  a_disable_read_only: assert property (
    wr_in && hit(addr_in, `GPL_OFF_DISABLE) && dis_locked
    |=> $stable(disable_reg_out) && status[`GPL_ST_REFUSED])
    else $error("locked disable register changed");

  a_disable_writable: assert property (
    wr_in && hit(addr_in, `GPL_OFF_DISABLE) && lock_mode && !level[2]
    |=> disable_reg_out == $past(wdata_in))
    else $error("unlocked disable register write lost");

  // a write-one clear right after the set may drop the bit again
  a_irq3_sets_flag: assert property (
    edge_seen[2] && func_c == GPL_C_IRQ
    |=> status[`GPL_ST_IRQ3]
        ##1 (irq_out || !(status[`GPL_ST_IRQ3] && mask[`GPL_ST_IRQ3])))
    else $error("pin C edge did not raise status");

  a_irq2_sets_flag: assert property (
    edge_seen[0] && func_a == GPL_A_IRQ
    |=> status[`GPL_ST_IRQ2])
    else $error("pin A edge did not raise status");

  a_irq_level_out: assert property (
    irq_out == |(status & mask))
    else $error("interrupt level disagrees with status and mask");

  a_rsvd_read_b: assert property (
    rd_in && hit(addr_in, `GPL_OFF_PIN_B) |=> rdata_out[6:3] == 4'h0)
    else $error("reserved bits of pin B read nonzero");

  c_lock_engaged: cover property (
    !lock_mode ##1 lock_mode ##[1:20] level[2]);
  c_write_refused: cover property (events[`GPL_ST_REFUSED]);
  c_irq_raised: cover property (!irq_out ##1 irq_out);
  c_wake_routed: cover property (
    pin_b_config[2] && !pin_b_config[0] ##1 $fell(pad_out[1]));
endmodule

// ### tb/gpl_pin_config_lock_tb_top.sv
`include "gpl_defines.svh"

// one comparison, counted; a mismatch is reported at once
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end

module gpl_pin_config_lock_tb_top import gpl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    string     nm;
    gpl_byte_t v;
  } gpl_note_s;

  logic       ref_clk_in;
  logic       rst_b_in;
  logic       main_rst_b;
  logic       bus_rst_b;
  logic       wr_s;
  logic       rd_s;
  logic       rd_d;
  logic       dens;
  logic       wake;
  logic       irq;
  logic       lock;
  logic [7:0] addr;
  logic [2:0] pad_i;
  logic [2:0] pad_o;
  logic [2:0] pad_oe_b;
  gpl_byte_t  wdata;
  gpl_byte_t  rdata;
  gpl_byte_t  dis;
  gpl_note_s  notes[$];
  gpl_note_s  nt;
  int         fails;
  int         n_checks;
  int         seed;
  int         i;
  // reset-value table: three configs, status, mask, disable, unmapped
  logic [7:0] r_addr[7] = '{8'h3C, 8'h3D, 8'h3E, 8'h48, 8'h49, 8'h4A, 8'h50};
  gpl_byte_t  r_exp[7]  = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
  // pin B drive table with data bit 1 set: config, pad value, enable
  gpl_byte_t  b_cfg[5]  = '{8'h00, 8'h02, 8'h80, 8'h82, 8'h01};
  logic       b_out[5]  = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
  logic       b_oe[5]   = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};

  gpl_top u_gpl_top (
    .ref_clk_in                (ref_clk_in),
    .rst_b_in                  (rst_b_in),
    .main_rst_b_in             (main_rst_b),
    .bus_rst_b_in              (bus_rst_b),
    .addr_in                   (addr),
    .wdata_in                  (wdata),
    .wr_in                     (wr_s),
    .rd_in                     (rd_s),
    .rdata_out                 (rdata),
    .pad_in                    (pad_i),
    .pad_out                   (pad_o),
    .pad_oe_b_out              (pad_oe_b),
    .drive_density_in          (dens),
    .wake_event_in             (wake),
    .irq_out                   (irq),
    .disable_reg_out           (dis),
    .disable_reg_lock_ctrl_out (lock)
  );

  // ----------------------------------------------------------------------
  // clock, bus tasks and read monitor
  // ----------------------------------------------------------------------
  // 50 MHz
  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask

  // a gap cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [7:0] a, input gpl_byte_t d);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge ref_clk_in);
    wr_s  <= 1'b0;
    @(posedge ref_clk_in);
  endtask

  task automatic rd(input logic [7:0] a, input gpl_byte_t e, input string nm);
    notes.push_back(gpl_note_s'{nm, e});
    addr <= a;
    rd_s <= 1'b1;
    @(posedge ref_clk_in);
    rd_s <= 1'b0;
    @(posedge ref_clk_in);
  endtask

  // read data stand only in the cycle after the strobe: look mid-cycle
  always @(posedge ref_clk_in) rd_d <= rd_s;
  always @(negedge ref_clk_in) begin
    if (rd_d) begin
      nt = notes.pop_front();
      `CHK(nt.nm, nt.v, rdata)
    end
  end

  // edge interrupt: masked, unmasked, cleared, then the opposite edge
  task automatic irq_run(input logic [7:0] a, input gpl_byte_t cfg,
                         input int pb, input int sb);
    gpl_byte_t m;
    m = 8'h01 << sb;
    wr(a, cfg);
    wr(`GPL_OFF_MASK, 8'h00);
    pad_i[pb] <= ~pad_i[pb];
    tick(6);
    `CHK("irq masked", 1'b0, irq)
    rd(`GPL_OFF_STATUS, m, "status");
    wr(`GPL_OFF_MASK, m);
    tick(2);
    `CHK("irq on", 1'b1, irq)
    wr(`GPL_OFF_STATUS, m);
    tick(2);
    `CHK("irq cleared", 1'b0, irq)
    pad_i[pb] <= ~pad_i[pb];
    tick(6);
    `CHK("irq other edge", 1'b1, irq)
    wr(`GPL_OFF_STATUS, m);
    rd(`GPL_OFF_STATUS, 8'h00, "status clr");
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // watchdog and main sequence
  // ----------------------------------------------------------------------
  // the tests need well under 2000 cycles
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    fails++;
    close_out();
  end

  initial begin
    {rst_b_in, wr_s, rd_s, dens, wake} = 5'h00;
    {main_rst_b, bus_rst_b} = 2'b11;
    addr = 8'h00;
    wdata = 8'h00;
    pad_i = 3'h0;
    seed = 10;
    tick(20);
    rst_b_in <= 1'b1;
    tick(1);
    wr(8'h50, 8'hFF);
    for (i = 0; i < 7; i++) begin
      rd(r_addr[i], r_exp[i], "reset value");
    end
    `CHK("oe_b reset", 3'h7, pad_oe_b)
    `CHK("lock reset", 1'b0, lock)
    $display("test reset done");

    wr(`GPL_OFF_PIN_A, 8'hFF);
    rd(`GPL_OFF_PIN_A, 8'h8F, "pin a mask");
    wr(`GPL_OFF_PIN_B, 8'hFF);
    rd(`GPL_OFF_PIN_B, 8'h87, "pin b mask");
    wr(`GPL_OFF_PIN_C, 8'h7F);
    rd(`GPL_OFF_PIN_C, 8'h0F, "pin c mask");
    wr(`GPL_OFF_PIN_C, 8'h01);
    $display("test reserved done");

    wr(`GPL_OFF_DATA, 8'h02);
    for (i = 0; i < 5; i++) begin
      wr(`GPL_OFF_PIN_B, b_cfg[i]);
      tick(3);
      `CHK("oe_b pin b", b_oe[i], pad_oe_b[1])
      if (!b_oe[i]) `CHK("pad pin b", b_out[i], pad_o[1])
    end
    $display("test drive done");

    wr(`GPL_OFF_PIN_B, 8'h04);
    for (i = 0; i < 4; i++) begin
      wake <= 1'($random(seed));
      tick(3);
      `CHK("wake pad", ~wake, pad_o[1])
      `CHK("wake oe_b", 1'b0, pad_oe_b[1])
    end
    wr(`GPL_OFF_PIN_B, 8'h86);
    wake <= 1'b1;
    tick(3);
    `CHK("wake od off", 1'b1, pad_oe_b[1])
    wake <= 1'b0;
    tick(3);
    `CHK("wake od low", 1'b0, pad_oe_b[1])
    $display("test wake done");

    wr(`GPL_OFF_PIN_A, 8'h04);
    for (i = 0; i < 4; i++) begin
      dens <= 1'($random(seed));
      tick(3);
      `CHK("density pad", dens, pad_o[0])
    end
    irq_run(`GPL_OFF_PIN_A, 8'h09, 0, 0);
    irq_run(`GPL_OFF_PIN_C, 8'h0D, 2, 1);
    $display("test irq done");

    // lock mode: writes to the field are dropped, pad forced to input
    wr(`GPL_OFF_PIN_C, 8'h07);
    tick(2);
    `CHK("lock on", 1'b1, lock)
    wr(`GPL_OFF_PIN_C, 8'h8A);
    rd(`GPL_OFF_PIN_C, 8'h86, "field held");
    tick(2);
    `CHK("lock input", 1'b1, pad_oe_b[2])
    pad_i[2] <= 1'b1;
    tick(4);
    // pin C reads its pad straight although its polarity bit is set
    rd(`GPL_OFF_DATA, 8'h26, "lock polarity");
    wr(`GPL_OFF_DISABLE, 8'h5A);
    rd(`GPL_OFF_DISABLE, 8'h00, "disable ro");
    `CHK("disable out", 8'h00, dis)
    rd(`GPL_OFF_STATUS, 8'h04, "refused");
    pad_i[2] <= 1'b0;
    tick(4);
    wr(`GPL_OFF_DISABLE, 8'hA5);
    rd(`GPL_OFF_DISABLE, 8'hA5, "disable rw");
    main_rst_b <= 1'b0;
    tick(1);
    main_rst_b <= 1'b1;
    tick(1);
    rd(`GPL_OFF_PIN_C, 8'h82, "main reset");
    `CHK("lock off", 1'b0, lock)
    wr(`GPL_OFF_PIN_C, 8'h07);
    bus_rst_b <= 1'b0;
    tick(1);
    bus_rst_b <= 1'b1;
    tick(1);
    rd(`GPL_OFF_PIN_C, 8'h03, "bus reset");
    $display("test lock done");
    tick(2);
    close_out();
  end
endmodule
